// ==== src/lpg_pkg.sv ====
// Constants shared by the laser PWM command gate.
// What this block does
// - Base frequencies 5, 10 and 20 kHz
// - 5 kHz is the default base frequency
// - High time 0 to 190 us at 5 kHz
// - Duty equals commanded share of period
// - Output high means beam on, low off
// - Local manual modes take duty from knob
// - Host manual modes take duty from host
// - Analog modes take duty from analog input
// - Current loop: zero at 4 mA, max 20 mA
// - Gate high requests on, low requests off
// - Active gate emits pulses at set duty
// - Pulse timing free-running, not gate aligned
// - Fire only when gate AND emission switch
// - Default-active setting treats undriven gate active
// - Default-inactive setting treats undriven gate inactive
// - Gate honoured in every operating mode
// - 1 us keep-alive pulses while output low
// - Voltage mode: zero at 0 V, max 10 V
`default_nettype none
package lpg_pkg;
    localparam int unsigned CLK_HZ      = 20_000_000;
    localparam int unsigned US_PER_S    = 1_000_000;
    // Base periods in microseconds
    localparam int unsigned PER_5K_US   = 200;
    localparam int unsigned PER_10K_US  = 100;
    localparam int unsigned PER_20K_US  = 50;
    localparam int unsigned PER_5K_CYC  = CLK_HZ / US_PER_S * PER_5K_US;
    localparam int unsigned PER_10K_CYC = CLK_HZ / US_PER_S * PER_10K_US;
    localparam int unsigned PER_20K_CYC = CLK_HZ / US_PER_S * PER_20K_US;
    // Keep-alive pulse width and spacing
    localparam int unsigned TICK_W_US   = 1;
    localparam int unsigned TICK_P_US   = 200;
    localparam int unsigned TICK_W_CYC  = CLK_HZ / US_PER_S * TICK_W_US;
    localparam int unsigned TICK_P_CYC  = CLK_HZ / US_PER_S * TICK_P_US;
    // Duty is held in tenths of a percent
    localparam int unsigned DUTY_FULL   = 1000;
    localparam int unsigned DUTY_MAX    = 950;
    // Frequency select codes
    localparam logic [1:0] FREQ_5K  = 2'h0;
    localparam logic [1:0] FREQ_10K = 2'h1;
    localparam logic [1:0] FREQ_20K = 2'h2;
    // Operating modes
    typedef enum logic [2:0] {
        MODE_MANUAL      = 3'b000,
        MODE_CURRENT     = 3'b001,
        MODE_VOLTAGE     = 3'b010,
        MODE_KNOB_REG    = 3'b011,
        MODE_VOLTAGE_REG = 3'b100
    } lpg_mode_e;
    // Register offsets (byte addresses)
    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_DUTY   = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h8;
    // Control field positions
    localparam int unsigned CTRL_FREQ_LSB = 0;
    localparam int unsigned CTRL_MODE_LSB = 2;
    localparam int unsigned CTRL_HOST_BIT = 5;
    localparam int unsigned CTRL_GDEF_BIT = 6;
    localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
    // Status field positions
    localparam int unsigned STAT_CMD_BIT  = 0;
    localparam int unsigned STAT_FIRE_BIT = 1;
    localparam int unsigned STAT_TICK_BIT = 2;
    localparam int unsigned STAT_DUTY_LSB = 16;
    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : lpg_pkg
`default_nettype wire

// ==== src/lpg_laser_pwm_command_gate.sv ====
// Laser PWM command generator with gate qualification and register slave.
//
// Register access over AXI4-Lite and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module lpg_laser_pwm_command_gate #(
    parameter int unsigned ADC_W     = 12,   // Analog input code width
    parameter int unsigned ADC_4MA   = 819,  // Code at 4 mA
    parameter int unsigned ADC_20MA  = 4095, // Code at 20 mA / 10 V
    parameter int unsigned TICK_PER  = lpg_pkg::TICK_P_CYC
) (
    input  wire logic             sys_clk,
    input  wire logic             reset,
    // AXI4-Lite slave
    input  wire logic [3:0]       s_axi_awaddr,
    input  wire logic             s_axi_awvalid,
    output logic                  s_axi_awready,
    input  wire logic [31:0]      s_axi_wdata,
    input  wire logic [3:0]       s_axi_wstrb,
    input  wire logic             s_axi_wvalid,
    output logic                  s_axi_wready,
    output logic [1:0]            s_axi_bresp,
    output logic                  s_axi_bvalid,
    input  wire logic             s_axi_bready,
    input  wire logic [3:0]       s_axi_araddr,
    input  wire logic             s_axi_arvalid,
    output logic                  s_axi_arready,
    output logic [31:0]           s_axi_rdata,
    output logic [1:0]            s_axi_rresp,
    output logic                  s_axi_rvalid,
    input  wire logic             s_axi_rready,
    // Front panel and external inputs
    input  wire logic [9:0]       knobDuty,
    input  wire logic [ADC_W-1:0] analogCode,
    input  wire logic             gateIn,
    input  wire logic             gateDriven,
    input  wire logic             emissionSwitch,
    // Laser outputs
    output logic                  cmdOut_ff,
    output logic                  tickleOut_ff
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);

    logic [31:0] ctrl_ff;         // Control register
    logic [9:0]  hostDuty_ff;     // Host duty, tenths of a percent
    logic [3:0]  awAddr_ff;       // Captured write address
    logic        awHave_ff;       // Write address held
    logic [31:0] wData_ff;        // Captured write data
    logic [3:0]  wStrb_ff;        // Captured byte enables
    logic        wHave_ff;        // Write data held
    logic [11:0] perTop_ff;       // Active period minus one
    logic [11:0] perCnt_ff;       // Free-running period counter
    logic [11:0] highCyc_ff;      // Active high time in cycles
    logic [9:0]  actDuty_ff;      // Active duty
    logic        fireEn_ff;       // Gate AND emission
    logic [11:0] lowCnt_ff;       // Cycles since output went low or since the last keep-alive pulse started
    logic [4:0]  tickCnt_ff;      // Remaining keep-alive width
    logic [9:0]  nxt_duty;        // Selected duty
    logic [11:0] nxt_highCyc;     // High time from selected duty
    logic [11:0] nxt_perTop;      // Period minus one from selected frequency
    logic        nxt_cmd;         // Next command level
    logic        gateActive;      // Effective gate level
    lpg_pkg::lpg_mode_e mode;     // Decoded mode

    // Period in cycles minus one for a frequency code
    function automatic logic [11:0] periodFor(input logic [1:0] sel);
        case (sel)
            lpg_pkg::FREQ_10K: periodFor = 12'(lpg_pkg::PER_10K_CYC - 1);
            lpg_pkg::FREQ_20K: periodFor = 12'(lpg_pkg::PER_20K_CYC - 1);
            default:           periodFor = 12'(lpg_pkg::PER_5K_CYC - 1);
        endcase
    endfunction : periodFor

    // Clamp a duty to the maximum
    function automatic logic [9:0] clampDuty(input logic [9:0] d);
        clampDuty = (d > 10'(lpg_pkg::DUTY_MAX)) ? 10'(lpg_pkg::DUTY_MAX) : d;
    endfunction : clampDuty

    assign mode = lpg_pkg::lpg_mode_e'(ctrl_ff[lpg_pkg::CTRL_MODE_LSB +: 3]);

    // Duty source selection and scaling
    always_comb begin
        logic [21:0] prod;
        prod = 22'h0;
        case (mode)
            lpg_pkg::MODE_CURRENT: begin
                // Zero at 4 mA, full at 20 mA
                if (analogCode > ADC_W'(ADC_4MA)) begin
                    prod = 22'((32'(analogCode) - ADC_4MA) * lpg_pkg::DUTY_MAX
                          / (ADC_20MA - ADC_4MA));
                end
            end
            lpg_pkg::MODE_VOLTAGE, lpg_pkg::MODE_VOLTAGE_REG: begin
                // Zero at 0 V, full at 10 V
                prod = 22'(32'(analogCode) * lpg_pkg::DUTY_MAX
                      / ADC_20MA);
            end
            default: begin
                // Manual modes: knob locally, register under host
                if (ctrl_ff[lpg_pkg::CTRL_HOST_BIT]) begin
                    prod = 22'(hostDuty_ff);
                end else begin
                    prod = 22'(knobDuty);
                end
            end
        endcase
        nxt_duty    = clampDuty(prod[9:0] | {10{|prod[21:10]}});
        nxt_perTop  = periodFor(ctrl_ff[lpg_pkg::CTRL_FREQ_LSB +: 2]);
        nxt_highCyc = 12'((32'(nxt_perTop) + 1) * nxt_duty
                      / lpg_pkg::DUTY_FULL);
    end

    // Undriven gate takes the configured idle level
    assign gateActive = gateDriven ? gateIn
                        : ctrl_ff[lpg_pkg::CTRL_GDEF_BIT];

    // Fire enable: gate AND emission switch in every mode
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            fireEn_ff <= 1'b0;
        end else begin
            fireEn_ff <= gateActive && emissionSwitch;
        end
    end

    // Free-running period counter; settings load on wrap
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            perCnt_ff  <= 12'h000;
            perTop_ff  <= 12'(lpg_pkg::PER_5K_CYC - 1);
            highCyc_ff <= 12'h000;
            actDuty_ff <= 10'h000;
        end else if (perCnt_ff >= perTop_ff) begin
            perCnt_ff  <= 12'h000;
            perTop_ff  <= nxt_perTop;
            highCyc_ff <= nxt_highCyc;
            actDuty_ff <= nxt_duty;
        end else begin
            perCnt_ff <= perCnt_ff + 12'h001;
        end
    end

    assign nxt_cmd = fireEn_ff && (perCnt_ff < highCyc_ff);

    // Command output
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            cmdOut_ff <= 1'b0;
        end else begin
            cmdOut_ff <= nxt_cmd;
        end
    end

    // Keep-alive pulses while the command is low
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            lowCnt_ff    <= 12'h000;
            tickCnt_ff   <= 5'h00;
            tickleOut_ff <= 1'b0;
        end else if (nxt_cmd) begin
            // One below zero: first pulse a full period after the fall
            lowCnt_ff    <= 12'hfff;
            tickCnt_ff   <= 5'h00;
            tickleOut_ff <= 1'b0;
        end else if (lowCnt_ff == 12'(TICK_PER - 1)) begin
            lowCnt_ff    <= 12'h000;
            tickCnt_ff   <= 5'(lpg_pkg::TICK_W_CYC - 1);
            tickleOut_ff <= 1'b1;
        end else begin
            lowCnt_ff    <= lowCnt_ff + 12'h001;
            tickleOut_ff <= tickCnt_ff != 5'h00;
            if (tickCnt_ff != 5'h00) begin
                tickCnt_ff <= tickCnt_ff - 5'h01;
            end
        end
    end

    // Write channel capture, address and data in either order
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            awHave_ff <= 1'b0;
            wHave_ff  <= 1'b0;
            awAddr_ff <= 4'h0;
            wData_ff  <= 32'h0000_0000;
            wStrb_ff  <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHave_ff <= 1'b1;
                awAddr_ff <= s_axi_awaddr;
            end else if (s_axi_bvalid && s_axi_bready) begin
                awHave_ff <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHave_ff <= 1'b1;
                wData_ff <= s_axi_wdata;
                wStrb_ff <= s_axi_wstrb;
            end else if (s_axi_bvalid && s_axi_bready) begin
                wHave_ff <= 1'b0;
            end
        end
    end

    // Ready while nothing of that channel is held
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else begin
            s_axi_awready <= !awHave_ff && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready  <= !wHave_ff && !(s_axi_wvalid && s_axi_wready);
        end
    end

    // Register write and write response
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ctrl_ff      <= lpg_pkg::CTRL_RESET;
            hostDuty_ff  <= 10'h000;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= lpg_pkg::RESP_OKAY;
        end else if (s_axi_bvalid) begin
            if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end else if (awHave_ff && wHave_ff) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= lpg_pkg::RESP_OKAY;
            case (awAddr_ff)
                lpg_pkg::REG_CTRL: begin
                    if (wStrb_ff[0]) begin
                        ctrl_ff[7:0] <= wData_ff[7:0];
                    end
                end
                lpg_pkg::REG_DUTY: begin
                    if (wStrb_ff[0]) begin
                        hostDuty_ff[7:0] <= wData_ff[7:0];
                    end
                    if (wStrb_ff[1]) begin
                        hostDuty_ff[9:8] <= wData_ff[9:8];
                    end
                end
                lpg_pkg::REG_STATUS: begin
                    // Read only, write ignored
                end
                default: begin
                    s_axi_bresp <= lpg_pkg::RESP_SLVERR;
                end
            endcase
        end
    end

    // Read channel
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= lpg_pkg::RESP_OKAY;
        end else if (s_axi_rvalid) begin
            s_axi_arready <= 1'b0;
            if (s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
            end
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= lpg_pkg::RESP_OKAY;
            s_axi_rdata   <= 32'h0000_0000;
            case (s_axi_araddr)
                lpg_pkg::REG_CTRL:   s_axi_rdata <= {24'h000000, ctrl_ff[7:0]};
                lpg_pkg::REG_DUTY:   s_axi_rdata <= {22'h000000, hostDuty_ff};
                lpg_pkg::REG_STATUS: begin
                    s_axi_rdata[lpg_pkg::STAT_CMD_BIT]  <= cmdOut_ff;
                    s_axi_rdata[lpg_pkg::STAT_FIRE_BIT] <= fireEn_ff;
                    s_axi_rdata[lpg_pkg::STAT_TICK_BIT] <= tickleOut_ff;
                    s_axi_rdata[lpg_pkg::STAT_DUTY_LSB +: 10] <= actDuty_ff;
                end
                default: s_axi_rresp <= lpg_pkg::RESP_SLVERR;
            endcase
        end else begin
            s_axi_arready <= 1'b1;
        end
    end

    chk_duty_cap: assert property (actDuty_ff <= 10'(lpg_pkg::DUTY_MAX))
        else $error("active duty above maximum");
    chk_std_freq: assert property (
        ($past(ctrl_ff[1:0]) == lpg_pkg::FREQ_5K && perCnt_ff == 12'h000)
        |-> perTop_ff == 12'(lpg_pkg::PER_5K_CYC - 1))
        else $error("5 kHz period wrong");
    chk_period_wrap: assert property (
        (perCnt_ff == perTop_ff) |=> perCnt_ff == 12'h000)
        else $error("period counter did not wrap");
    chk_load_hold: assert property (
        (perCnt_ff < perTop_ff) |=> $stable(highCyc_ff) && $stable(perTop_ff))
        else $error("setting loaded inside a period");
    chk_fire_and: assert property (
        (!gateActive || !emissionSwitch) |=> ##1 !cmdOut_ff)
        else $error("command high without gate and emission");
    chk_high_time: assert property (
        (fireEn_ff && perCnt_ff < highCyc_ff) |=> cmdOut_ff)
        else $error("command low inside high time");
    chk_low_time: assert property (
        (perCnt_ff >= highCyc_ff) |=> !cmdOut_ff)
        else $error("command high outside high time");
    chk_tickle_excl: assert property (cmdOut_ff |-> !tickleOut_ff)
        else $error("keep-alive during command high");
    chk_tickle_gap: assert property (
        $fell(cmdOut_ff) |-> !tickleOut_ff [*8])
        else $error("keep-alive too soon after falling edge");
    chk_gate_idle: assert property (
        (!gateDriven && !ctrl_ff[lpg_pkg::CTRL_GDEF_BIT]) |=> !fireEn_ff)
        else $error("undriven gate fired with inactive idle");
    chk_bresp_pair: assert property (
        (awHave_ff && wHave_ff && !s_axi_bvalid) |=> s_axi_bvalid)
        else $error("write response missing");
endmodule : lpg_laser_pwm_command_gate
`default_nettype wire

// ==== tb/lpg_gate_source.sv ====
// Gate source model standing in for the external gating controller.
`timescale 1ns/1ps
`default_nettype none
module lpg_gate_source #(
    parameter int unsigned MIN_ON = 70  // Shortest on time, 3.5 us
) (
    input  wire logic sys_clk,
    input  wire logic reset,
    input  wire logic onReq,
    input  wire logic driveReq,
    output logic      gateIn,
    output logic      gateDriven
);
    logic [15:0] hold_ff;  // Cycles left of the minimum on time
    logic        level_ff; // Driven gate level
    logic        float_ff; // Changing level while undriven

    // Stretch every on request to the minimum width
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            hold_ff  <= 16'h0;
            level_ff <= 1'b0;
            float_ff <= 1'b0;
        end else begin
            float_ff <= ~float_ff;
            if (onReq) begin
                level_ff <= 1'b1;
                hold_ff  <= 16'(MIN_ON);
            end else if (hold_ff != 16'h0) begin
                hold_ff <= hold_ff - 16'h1;
            end else begin
                level_ff <= 1'b0;
            end
        end
    end

    // Released line shows no stable level
    assign gateIn     = driveReq ? level_ff : float_ff;
    assign gateDriven = driveReq;
endmodule : lpg_gate_source
`default_nettype wire

// ==== tb/lpg_laser_pwm_command_gate_bench.sv ====
// Self-checking bench for the laser PWM command gate.
`timescale 1ns/1ps
`default_nettype none
module lpg_laser_pwm_command_gate_bench;
    localparam int TICK  = 40;     // Shortened keep-alive spacing
    localparam int A4    = 819;    // Code at 4 mA
    localparam int A20   = 4095;   // Code at full scale
    localparam int LIMIT = 95000;  // Cycle ceiling
    localparam logic [1:0] F10 = lpg_pkg::FREQ_10K;
    localparam logic [1:0] F20 = lpg_pkg::FREQ_20K;
    localparam logic [2:0] MAN = lpg_pkg::MODE_MANUAL;
    logic        sys_clk = 1'b0;
    logic        reset = 1'b1;
    logic [3:0]  awAddr = 4'h0, arAddr = 4'h0;
    logic [31:0] wData = 32'h0, rData;
    logic        awValid = 1'b0, wValid = 1'b0, bReady = 1'b0;
    logic        arValid = 1'b0, rReady = 1'b0;
    logic        awReady, wReady, bValid, arReady, rValid;
    logic [1:0]  bResp, rResp;
    logic [9:0]  knobDuty = 10'h0;
    logic [11:0] analogCode = 12'h0;
    logic        gateReq = 1'b0, gateDrv = 1'b1, emission = 1'b0;
    logic        gateIn, gateDriven, cmdOut, tickleOut;
    int          bad_count = 0, n_tests = 0, cyc = 0, overlap = 0;
    int          lastPer = 4000;   // Period in force before a change

    // Clock, 50 ns period
    always #25 sys_clk = ~sys_clk;

    lpg_laser_pwm_command_gate #(.ADC_4MA(A4), .ADC_20MA(A20),
        .TICK_PER(TICK)) dut (.sys_clk(sys_clk), .reset(reset),
        .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
        .s_axi_awready(awReady), .s_axi_wdata(wData),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wValid),
        .s_axi_wready(wReady), .s_axi_bresp(bResp),
        .s_axi_bvalid(bValid), .s_axi_bready(bReady),
        .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
        .s_axi_arready(arReady), .s_axi_rdata(rData),
        .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
        .s_axi_rready(rReady), .knobDuty(knobDuty),
        .analogCode(analogCode), .gateIn(gateIn),
        .gateDriven(gateDriven), .emissionSwitch(emission),
        .cmdOut_ff(cmdOut), .tickleOut_ff(tickleOut));

    lpg_gate_source src (.sys_clk(sys_clk), .reset(reset),
        .onReq(gateReq), .driveReq(gateDrv), .gateIn(gateIn),
        .gateDriven(gateDriven));

    // Verdict and end of run
    task automatic test_done();
        if (bad_count == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : test_done

    // Hang guard
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            bad_count = bad_count + 1;
            test_done();
        end
    end

    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string msg);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %0t %s got %0h exp %0h", $time, msg,
                     got, exp);
        end
    endtask : chk

    // One register transfer; flags sampled before the taking edge
    task automatic bus(input bit wr, input logic [3:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic [1:0] r);
        bit aw, w, ar, done;
        done = 0;
        @(posedge sys_clk);
        if (wr) begin
            awAddr <= a;
            wData  <= d;
            awValid <= 1'b1;
            wValid <= 1'b1;
            bReady <= 1'b1;
        end else begin
            arAddr <= a;
            arValid <= 1'b1;
            rReady <= 1'b1;
        end
        while (!done) begin
            @(negedge sys_clk);
            aw = awValid && awReady;
            w  = wValid && wReady;
            ar = arValid && arReady;
            done = wr ? bValid : rValid;
            r = wr ? bResp : rResp;
            q = rData;
            @(posedge sys_clk);
            if (aw) awValid <= 1'b0;
            if (w) wValid <= 1'b0;
            if (ar) arValid <= 1'b0;
            if (done) bReady <= 1'b0;
            if (done) rReady <= 1'b0;
        end
    endtask : bus

    // Period length in cycles for a frequency code
    function automatic int perOf(input logic [1:0] f);
        case (f)
            F10: return int'(lpg_pkg::PER_10K_CYC);
            F20: return int'(lpg_pkg::PER_20K_CYC);
            default: return int'(lpg_pkg::PER_5K_CYC);
        endcase
    endfunction : perOf

    // Control word from its fields
    function automatic logic [6:0] cw(input logic [1:0] f,
        input logic [2:0] m, input logic h, input logic g);
        return {g, h, m, f};
    endfunction : cw

    // Count command and keep-alive high cycles over a window
    task automatic meas(input int n, output int h, output int t);
        h = 0;
        t = 0;
        repeat (n) begin
            @(negedge sys_clk);
            if (cmdOut === 1'b1) h++;
            if (tickleOut === 1'b1) t++;
            if (cmdOut === 1'b1 && tickleOut === 1'b1) overlap++;
        end
    endtask : meas

    // Apply settings, let them load, check high time over one period
    task automatic step(input logic [6:0] c, input int hd, kd, ac,
                        input logic [2:0] gde, input int ed);
        logic [31:0] q;
        logic [1:0]  r;
        int          per, h, t;
        per = perOf(c[1:0]);
        bus(1'b1, lpg_pkg::REG_CTRL, {25'h0, c}, q, r);
        bus(1'b1, lpg_pkg::REG_DUTY, 32'(hd), q, r);
        @(posedge sys_clk);
        knobDuty   <= 10'(kd);
        analogCode <= 12'(ac);
        {gateReq, gateDrv, emission} <= gde;
        repeat (lastPer + per + 4) @(posedge sys_clk);
        lastPer = per;
        meas(per, h, t);
        chk(32'(h), 32'(per * ed / 1000), "high time");
    endtask : step

    // Main sequence
    initial begin
        logic [31:0] q;
        logic [1:0]  r;
        int          kd, hd, h, t;
        void'($urandom(27704));
        repeat (16) @(posedge sys_clk);
        reset <= 1'b0;
        bus(1'b0, lpg_pkg::REG_CTRL, 32'h0, q, r);
        chk(q, lpg_pkg::CTRL_RESET, "control reset");
        bus(1'b0, 4'hc, 32'h0, q, r);
        chk(32'(r), 32'(lpg_pkg::RESP_SLVERR), "unmapped read");
        bus(1'b1, 4'hc, 32'h5, q, r);
        chk(32'(r), 32'(lpg_pkg::RESP_SLVERR), "unmapped write");
        kd = int'($urandom_range(949, 1));
        hd = int'($urandom_range(949, 1));
        step(cw(2'h0, MAN, 0, 0), 0, 1000, 0, 3'h7, 950);
        step(cw(2'h3, MAN, 0, 0), 0, kd, 0, 3'h7, kd);
        step(cw(F10, MAN, 0, 0), 0, kd, 0, 3'h7, kd);
        step(cw(F20, MAN, 1, 0), hd, kd, 0, 3'h7, hd);
        bus(1'b0, lpg_pkg::REG_DUTY, 32'h0, q, r);
        chk(q, 32'(hd), "host duty readback");
        step(cw(F20, 3'h3, 0, 0), 0, kd, 0, 3'h7, kd);
        step(cw(F20, 3'h1, 0, 0), 0, kd, A20, 3'h7, 950);
        step(cw(F20, 3'h1, 1, 0), hd, kd, A4, 3'h7, 0);
        step(cw(F20, 3'h2, 0, 0), 0, kd, A20, 3'h7, 950);
        step(cw(F20, 3'h2, 0, 0), 0, kd, 0, 3'h7, 0);
        step(cw(F20, 3'h4, 0, 0), 0, kd, A20, 3'h7, 950);
        step(cw(F20, MAN, 0, 0), 0, 500, 0, 3'h6, 0);
        step(cw(F20, MAN, 0, 0), 0, 500, 0, 3'h3, 0);
        meas(10 * TICK, h, t);
        chk(32'(t), 32'(10 * int'(lpg_pkg::TICK_W_CYC)),
            "keep-alive");
        step(cw(F20, MAN, 0, 0), 0, 500, 0, 3'h5, 0);
        step(cw(F20, MAN, 0, 1), 0, 500, 0, 3'h1, 500);
        bus(1'b0, lpg_pkg::REG_STATUS, 32'h0, q, r);
        chk(32'(q[lpg_pkg::STAT_FIRE_BIT]), 32'h1, "fire status");
        chk(32'(q[lpg_pkg::STAT_DUTY_LSB +: 10]), 32'd500,
            "active duty");
        // Emission off mid-pulse must cut the command within two cycles
        while (cmdOut !== 1'b1) @(negedge sys_clk);
        @(posedge sys_clk);
        emission <= 1'b0;
        repeat (3) @(negedge sys_clk);
        chk(32'(cmdOut), 32'h0, "cut by emission");
        chk(32'(overlap), 32'h0, "keep-alive while on");
        test_done();
    end
endmodule : lpg_laser_pwm_command_gate_bench
`default_nettype wire
